// >>> src/cms_slot_ctrl.sv
/*
  Message-slot control of one CAN channel: transmit scheduling, remote-frame
  responses, abort handling, receive slot selection and per-slot status.
  Assumes an outside frame engine that sends/receives frames on the bus, keeps
  payload bytes per slot, and reports outcomes as one-cycle pulses.
*/
module cms_slot_ctrl
  import cms_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // controller mode
  input  wire logic              op_mode,
  input  wire logic              dual_slot_mode,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // transmit request to frame engine
  output logic                   tx_req_valid,
  output logic      [SLOT_W-1:0] tx_slot,
  output logic                   tx_remote,
  output logic      [ID_W-1:0]   tx_id,
  output logic      [DLC_W-1:0]  tx_dlc,
  // transmit outcome from frame engine
  input  wire logic              tx_done,
  input  wire logic              tx_arb_lost,
  input  wire logic              tx_error,
  input  wire logic              bus_frame_end,
  // received frame from frame engine
  input  wire logic              rx_done,
  input  wire logic              rx_remote,
  input  wire logic [ID_W-1:0]   rx_id,
  input  wire logic [DLC_W-1:0]  rx_dlc,
  output logic                   rx_store,
  output logic      [SLOT_W-1:0] rx_slot,
  // success interrupt requests
  output logic                   tx_int_req,
  output logic                   rx_int_req
);

  // lowest set bit: {found, index}
  function automatic logic [SLOT_W:0] lowest(input logic [SLOTS-1:0] v);
    logic [SLOT_W:0] r;
    r = '0;
    for (int k = SLOTS - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = {1'b1, SLOT_W'(k)};
      end
    end
    return r;
  endfunction : lowest

  logic [SLOTS-1:0] treq, rreq, rmt, lock, ovw, act, tsuc, rsuc, abrt, rpend, await_d, inten;
  logic [SLOTS-1:0] next_treq, next_rreq, next_rmt, next_lock, next_ovw, next_act;
  logic [SLOTS-1:0] next_tsuc, next_rsuc, next_abrt, next_rpend, next_await_d, next_inten;
  logic [ID_W-1:0]   id_q      [SLOTS];
  logic [ID_W-1:0]   next_id_q [SLOTS];
  logic [DLC_W-1:0]  dlc_q      [SLOTS];
  logic [DLC_W-1:0]  next_dlc_q [SLOTS];
  logic [DLC_W-1:0]  rdlc_q      [SLOTS];
  logic [DLC_W-1:0]  next_rdlc_q [SLOTS];
  cms_state_t        state, next_state;
  logic [SLOT_W-1:0] cs, next_cs;
  logic              op_q, next_op_q;
  logic [DATA_W-1:0] next_reg_rdata;
  logic              next_tx_req_valid, next_tx_remote, next_rx_store;
  logic              next_tx_int_req, next_rx_int_req;
  logic [SLOT_W-1:0] next_tx_slot, next_rx_slot;
  logic [ID_W-1:0]   next_tx_id;
  logic [DLC_W-1:0]  next_tx_dlc;

  logic [SLOTS-1:0]  elig, dmatch, rmatch, resp;
  logic [SLOT_W:0]   pick_tx, pick_dat, pick_rmt;
  logic              wr_ok, is_ctrl, is_id, leave;
  logic [SLOT_W-1:0] wj, rj;

  always_comb begin
    for (int j = 0; j < SLOTS; j++) begin
      resp[j]   = rreq[j] & rmt[j];
      // remote answers are barred on the two dual-receive slots
      if (dual_slot_mode && SLOT_W'(j) >= DUAL_FIRST) begin
        resp[j] = 1'b0;
      end
      elig[j]   = (treq[j] & ~rreq[j] & ~await_d[j])
                | (resp[j] & rpend[j] & ~lock[j]);
      dmatch[j] = (id_q[j] == rx_id) & ~act[j]
                & ((rreq[j] & ~rmt[j] & ~lock[j]) | (treq[j] & rmt[j] & ~rreq[j]));
      rmatch[j] = (id_q[j] == rx_id) & resp[j] & ~act[j];
    end
    pick_tx  = lowest(elig);
    pick_dat = lowest(dmatch);
    pick_rmt = lowest(rmatch);
  end

  assign leave   = op_q & ~op_mode;
  assign wr_ok   = reg_wr & op_mode & op_q;
  assign is_ctrl = ((reg_addr & REGION_MASK) == CTRL_BASE) && (reg_addr[1:0] == 2'h0);
  assign is_id   = ((reg_addr & REGION_MASK) == ID_BASE) && (reg_addr[1:0] == 2'h0);
  assign wj      = reg_addr[SLOT_W+1:2];
  assign rj      = pick_dat[SLOT_W] ? pick_dat[SLOT_W-1:0] : pick_rmt[SLOT_W-1:0];

  always_comb begin
    next_treq = treq;   next_rreq = rreq;   next_rmt = rmt;     next_lock = lock;
    next_ovw = ovw;     next_act = act;     next_tsuc = tsuc;   next_rsuc = rsuc;
    next_abrt = abrt;   next_rpend = rpend; next_await_d = await_d;
    next_inten = inten;
    next_id_q = id_q;   next_dlc_q = dlc_q; next_rdlc_q = rdlc_q;
    next_state = state; next_cs = cs;       next_op_q = op_mode;
    next_tx_req_valid = 1'b0;
    next_tx_slot = tx_slot; next_tx_remote = tx_remote;
    next_tx_id = tx_id;     next_tx_dlc = tx_dlc;
    next_rx_store = 1'b0;   next_rx_slot = rx_slot;
    next_tx_int_req = 1'b0; next_rx_int_req = 1'b0;
    next_reg_rdata = '0;

    // software writes
    if (wr_ok && is_ctrl) begin
      // a cleared request on a slot still on the bus becomes an abort request
      if (act[wj] && ((treq[wj] && !resp[wj] && !reg_wdata[B_TREQ])
          || (resp[wj] && !reg_wdata[B_RREQ]))) begin
        next_abrt[wj] = 1'b1;
      end
      if (!act[wj]) begin
        next_treq[wj] = reg_wdata[B_TREQ];
        next_rreq[wj] = reg_wdata[B_RREQ];
        next_rmt[wj]  = reg_wdata[B_RMT];
        next_await_d[wj] = 1'b0;
        if (!reg_wdata[B_RREQ]) begin
          next_rpend[wj] = 1'b0;
        end
      end else begin
        next_treq[wj] = treq[wj] & reg_wdata[B_TREQ];
        next_rreq[wj] = rreq[wj] & reg_wdata[B_RREQ];
      end
      next_lock[wj] = reg_wdata[B_LOCK];
      next_ovw[wj]  = ovw[wj] & reg_wdata[B_OVW];
      next_tsuc[wj] = tsuc[wj] & reg_wdata[B_TSUC];
      next_rsuc[wj] = rsuc[wj] & reg_wdata[B_RSUC];
    end
    if (wr_ok && is_id) begin
      next_id_q[wj]  = reg_wdata[ID_LSB +: ID_W];
      next_dlc_q[wj] = reg_wdata[DLC_LSB +: DLC_W];
    end
    if (wr_ok && reg_addr == INTEN_ADDR) begin
      next_inten = reg_wdata[SLOTS-1:0];
    end

    // transmit sequencing; hardware events come after writes so a set wins
    case (state)
      CMS_IDLE: begin
        if (op_mode && op_q && pick_tx[SLOT_W]) begin
          next_cs    = pick_tx[SLOT_W-1:0];
          next_state = CMS_SEND;
          next_act[pick_tx[SLOT_W-1:0]] = 1'b1;
          next_tx_req_valid = 1'b1;
          next_tx_slot   = pick_tx[SLOT_W-1:0];
          next_tx_remote = rmt[pick_tx[SLOT_W-1:0]] & ~rreq[pick_tx[SLOT_W-1:0]];
          next_tx_id     = id_q[pick_tx[SLOT_W-1:0]];
          next_tx_dlc    = resp[pick_tx[SLOT_W-1:0]] ? rdlc_q[pick_tx[SLOT_W-1:0]]
                                                    : dlc_q[pick_tx[SLOT_W-1:0]];
        end
      end
      CMS_SEND: begin
        next_tx_req_valid = 1'b1;
        if (tx_done) begin
          // success completes even with an abort outstanding
          next_tx_req_valid = 1'b0;
          next_state  = CMS_IDLE;
          next_act[cs]  = 1'b0;
          next_abrt[cs] = 1'b0;
          next_tsuc[cs] = 1'b1;
          next_tx_int_req = inten[cs];
          if (resp[cs]) begin
            next_rpend[cs] = 1'b0;
          end else if (rmt[cs]) begin
            next_await_d[cs] = 1'b1;
          end else begin
            next_treq[cs] = 1'b0;
          end
        end else if (tx_arb_lost || tx_error) begin
          next_tx_req_valid = 1'b0;
          if (abrt[cs] || next_abrt[cs]) begin
            next_state    = CMS_IDLE;
            next_act[cs]  = 1'b0;
            next_abrt[cs] = 1'b0;
            next_rpend[cs] = 1'b0;
            next_treq[cs] = 1'b0;
            if (resp[cs]) begin
              next_rreq[cs] = 1'b0;
            end
          end else begin
            next_state = CMS_WAIT;
          end
        end
      end
      CMS_WAIT: begin
        if (bus_frame_end) begin
          if (abrt[cs] || next_abrt[cs]) begin
            next_state    = CMS_IDLE;
            next_act[cs]  = 1'b0;
            next_abrt[cs] = 1'b0;
            next_rpend[cs] = 1'b0;
            next_treq[cs] = 1'b0;
            if (resp[cs]) begin
              next_rreq[cs] = 1'b0;
            end
          end else begin
            next_state = CMS_SEND;
            next_tx_req_valid = 1'b1;
          end
        end
      end
      default: begin
        next_state = CMS_IDLE;
      end
    endcase

    // reception into the lowest matching slot; a remote frame is marked on the lowest data-matching slot when one exists
    if (rx_done && op_mode && op_q) begin
      if (!rx_remote && pick_dat[SLOT_W]) begin
        next_rx_store = 1'b1;
        next_rx_slot  = rj;
        next_ovw[rj]  = ovw[rj] | rsuc[rj];
        next_rsuc[rj] = 1'b1;
        next_dlc_q[rj] = rx_dlc;
        next_rx_int_req = inten[rj];
        // a matching data frame also cancels a remote request not yet sent
        if (rmt[rj]) begin
          next_treq[rj]    = 1'b0;
          next_await_d[rj] = 1'b0;
        end
      end else if (rx_remote && pick_rmt[SLOT_W]) begin
        next_rpend[rj]  = 1'b1;
        next_rdlc_q[rj] = rx_dlc;
      end
    end

    // leaving operation wipes slot state except the remote lengths in rdlc_q and stops the sequencer
    if (leave) begin
      next_treq = ZERO16;  next_rreq = ZERO16;  next_rmt = ZERO16;
      next_lock = ZERO16;  next_ovw = ZERO16;   next_act = ZERO16;
      next_tsuc = ZERO16;  next_rsuc = ZERO16;  next_abrt = ZERO16;
      next_rpend = ZERO16; next_await_d = ZERO16;
      next_inten = ZERO16;
      for (int j = 0; j < SLOTS; j++) begin
        next_id_q[j]  = '0;
        next_dlc_q[j] = '0;
      end
      next_state = CMS_IDLE;
      next_tx_req_valid = 1'b0;
    end

    // read data, one cycle after the strobe
    if (reg_rd) begin
      if (is_ctrl) begin
        next_reg_rdata[7:0] = {treq[wj], rreq[wj], rmt[wj], lock[wj],
                               ovw[wj], act[wj], tsuc[wj], rsuc[wj]};
      end else if (is_id) begin
        next_reg_rdata[ID_LSB +: ID_W]    = id_q[wj];
        next_reg_rdata[DLC_LSB +: DLC_W]  = dlc_q[wj];
        next_reg_rdata[RDLC_LSB +: DLC_W] = rdlc_q[wj];
      end else if (reg_addr == INTEN_ADDR) begin
        next_reg_rdata[SLOTS-1:0] = inten;
      end else if (reg_addr == STAT_ADDR) begin
        next_reg_rdata[7:0] = {1'b0, op_q, state, cs};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      treq <= '0;  rreq <= '0;  rmt <= '0;   lock <= '0;  ovw <= '0;  act <= '0;
      tsuc <= '0;  rsuc <= '0;  abrt <= '0;  rpend <= '0; await_d <= '0;
      inten <= '0;
      for (int j = 0; j < SLOTS; j++) begin
        id_q[j]   <= '0;
        dlc_q[j]  <= '0;
        rdlc_q[j] <= '0;
      end
      state <= CMS_IDLE;
      cs    <= '0;
      op_q  <= 1'b0;
      reg_rdata    <= '0;
      tx_req_valid <= 1'b0;
      tx_slot      <= '0;
      tx_remote    <= 1'b0;
      tx_id        <= '0;
      tx_dlc       <= '0;
      rx_store     <= 1'b0;
      rx_slot      <= '0;
      tx_int_req   <= 1'b0;
      rx_int_req   <= 1'b0;
    end else begin
      treq <= next_treq;   rreq <= next_rreq;   rmt <= next_rmt;
      lock <= next_lock;   ovw <= next_ovw;     act <= next_act;
      tsuc <= next_tsuc;   rsuc <= next_rsuc;   abrt <= next_abrt;
      rpend <= next_rpend; await_d <= next_await_d;
      inten <= next_inten;
      id_q   <= next_id_q;
      dlc_q  <= next_dlc_q;
      rdlc_q <= next_rdlc_q;
      state <= next_state;
      cs    <= next_cs;
      op_q  <= next_op_q;
      reg_rdata    <= next_reg_rdata;
      tx_req_valid <= next_tx_req_valid;
      tx_slot      <= next_tx_slot;
      tx_remote    <= next_tx_remote;
      tx_id        <= next_tx_id;
      tx_dlc       <= next_tx_dlc;
      rx_store     <= next_rx_store;
      rx_slot      <= next_rx_slot;
      tx_int_req   <= next_tx_int_req;
      rx_int_req   <= next_rx_int_req;
    end
  end

endmodule : cms_slot_ctrl

// >>> pkg/cms_pkg.sv
/*
  Constants, register map and state type for the CAN message-slot control block.
  Assumes one channel of 16 slots and an outside frame engine that holds slot payloads.
*/
package cms_pkg;
  localparam int          SLOTS      = 16;
  localparam int          SLOT_W     = 4;
  localparam int          ID_W       = 11;
  localparam int          DLC_W      = 4;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;

  // register byte addresses
  localparam logic [7:0]  REGION_MASK = 8'hC0;
  localparam logic [7:0]  CTRL_BASE   = 8'h00;
  localparam logic [7:0]  ID_BASE     = 8'h40;
  localparam logic [7:0]  INTEN_ADDR  = 8'h80;
  localparam logic [7:0]  STAT_ADDR   = 8'h84;

  // slot control byte
  localparam int          B_TREQ     = 7;
  localparam int          B_RREQ     = 6;
  localparam int          B_RMT      = 5;
  localparam int          B_LOCK     = 4;
  localparam int          B_OVW      = 3;
  localparam int          B_ACT      = 2;
  localparam int          B_TSUC     = 1;
  localparam int          B_RSUC     = 0;

  // id register fields
  localparam int          ID_LSB     = 0;
  localparam int          DLC_LSB    = 16;
  localparam int          RDLC_LSB   = 20;

  localparam logic [3:0]  DUAL_FIRST = 4'hE;
  localparam logic [15:0] ZERO16     = 16'h0000;

  typedef enum logic [1:0] {
    CMS_IDLE = 2'h0,
    CMS_SEND = 2'h1,
    CMS_WAIT = 2'h3
  } cms_state_t;
endpackage : cms_pkg

// >>> bench/cms_slot_ctrl_props.sv
/*
  Port-level checks of the message-slot control block.
  Assumes a bind onto cms_slot_ctrl, one clock and synchronous active-high reset.
*/
module cms_slot_ctrl_props
  import cms_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // mode and register port
  input wire logic              op_mode,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // transmit link
  input wire logic              tx_req_valid,
  input wire logic [SLOT_W-1:0] tx_slot,
  input wire logic              tx_remote,
  input wire logic [ID_W-1:0]   tx_id,
  input wire logic [DLC_W-1:0]  tx_dlc,
  input wire logic              tx_done,
  input wire logic              tx_arb_lost,
  input wire logic              tx_error,
  input wire logic              bus_frame_end,
  // receive link and interrupts
  input wire logic              rx_done,
  input wire logic              rx_remote,
  input wire logic              rx_store,
  input wire logic              tx_int_req,
  input wire logic              rx_int_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // high from a lost or broken frame until the bus reports its end
  logic wait_q;
  logic next_wait;
  always_comb begin
    next_wait = wait_q;
    if (tx_req_valid && (tx_arb_lost || tx_error)) next_wait = 1'b1;
    if (bus_frame_end || rst || !op_mode) next_wait = 1'b0;
  end
  always_ff @(posedge sys_clk) begin
    wait_q <= next_wait;
  end
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside the answer cycle");
  AST_TX_HOLD: assert property (tx_req_valid && $past(tx_req_valid)
    |-> $stable({tx_slot, tx_remote, tx_id, tx_dlc}))
    else $error("offered frame changed while offered");
  AST_TX_DROP: assert property ($past(tx_req_valid && (tx_done || tx_arb_lost || tx_error))
    |-> !tx_req_valid)
    else $error("offer stayed up after its outcome");
  AST_RETRY: assert property (!(wait_q && tx_req_valid))
    else $error("retry offered before the winning frame ended");
  AST_TX_INT: assert property (tx_int_req |-> $past(tx_done && tx_req_valid))
    else $error("transmit interrupt without a successful send");
  AST_RX_INT: assert property (rx_int_req |-> rx_store && $past(rx_done))
    else $error("receive interrupt without a stored frame");
  AST_RX_DATA: assert property (rx_store |-> $past(rx_done && !rx_remote))
    else $error("store without a received data frame");
  AST_OFFLINE: assert property ($past(!op_mode) |-> !tx_req_valid && !rx_store)
    else $error("traffic outside operating mode");
endmodule : cms_slot_ctrl_props

// >>> bench/cms_engine_model.sv
/*
  Behavioural frame engine standing for the bus and the other nodes.
  Assumes the offer and outcome handshake of the slot control block.
*/
module cms_engine_model
  import cms_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              tx_req_valid,
  input  wire logic [SLOT_W-1:0] tx_slot,
  input  wire logic              tx_remote,
  input  wire logic [ID_W-1:0]   tx_id,
  input  wire logic [DLC_W-1:0]  tx_dlc,
  output logic                   tx_done,
  output logic                   tx_arb_lost,
  output logic                   tx_error,
  output logic                   bus_frame_end,
  output logic                   rx_done,
  output logic                   rx_remote,
  output logic      [ID_W-1:0]   rx_id,
  output logic      [DLC_W-1:0]  rx_dlc,
  input  wire logic              rx_store,
  input  wire logic [SLOT_W-1:0] rx_slot
);
  timeunit 1ns;
  timeprecision 1ps;
  int          n_lose  = 0;
  logic        use_err = 1'b0;
  logic [31:0] offers[$];
  logic [3:0]  stores[$];
  initial begin
    {tx_done, tx_arb_lost, tx_error, bus_frame_end, rx_done, rx_remote} = '0;
    rx_id  = '0;
    rx_dlc = '0;
    forever begin
      @(posedge sys_clk);
      if (tx_req_valid === 1'b1 && !rst) begin
        offers.push_back({12'h000, tx_slot, tx_remote, tx_dlc, tx_id});
        repeat (5) @(posedge sys_clk);
        if (n_lose > 0) begin
          n_lose--;
          if (use_err) tx_error <= 1'b1;
          else tx_arb_lost <= 1'b1;
        end else tx_done <= 1'b1;
        @(posedge sys_clk);
        {tx_done, tx_arb_lost, tx_error} <= '0;
        // the winner or the error frame keeps the bus for a while
        repeat (2) @(posedge sys_clk);
        bus_frame_end <= 1'b1;
        @(posedge sys_clk);
        // the offer has dropped by now; a new one already up is taken next loop
        bus_frame_end <= 1'b0;
      end
    end
  end
  // a received frame as the engine reports it; id and length are scrambled afterwards
  task automatic rx_frame(input logic rmt, input logic [ID_W-1:0] id, input logic [DLC_W-1:0] d);
    @(posedge sys_clk);
    rx_done   <= 1'b1;
    rx_remote <= rmt;
    rx_id     <= id;
    rx_dlc    <= d;
    @(posedge sys_clk);
    rx_done <= 1'b0;
    rx_id   <= ~id;
    rx_dlc  <= ~d;
  endtask : rx_frame
  always @(posedge sys_clk) begin
    if (rx_store === 1'b1) stores.push_back(rx_slot);
  end
endmodule : cms_engine_model

// >>> bench/cms_slot_ctrl_tb.sv
/*
  Self-checking bench of the slot control block with a frame engine model.
  Assumes a 50 MHz clock and software access through the plain register port.
*/
bind cms_slot_ctrl cms_slot_ctrl_props u_props (.sys_clk, .rst, .op_mode, .reg_rd, .reg_rdata,
  .tx_req_valid, .tx_slot, .tx_remote, .tx_id, .tx_dlc, .tx_done, .tx_arb_lost, .tx_error,
  .bus_frame_end, .rx_done, .rx_remote, .rx_store, .tx_int_req, .rx_int_req);
module cms_slot_ctrl_tb
  import cms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk, rst, op_mode, dual_slot_mode, reg_wr, reg_rd, tx_req_valid;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic              tx_remote, tx_done, tx_arb_lost, tx_error, bus_frame_end, rx_done;
  logic [SLOT_W-1:0] tx_slot, rx_slot;
  logic [ID_W-1:0]   tx_id, rx_id;
  logic [DLC_W-1:0]  tx_dlc, rx_dlc;
  logic              rx_remote, rx_store, tx_int_req, rx_int_req;
  int                n_errors, n_tests, n_txi, n_rxi;
  cms_slot_ctrl dut (.sys_clk, .rst, .op_mode, .dual_slot_mode, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_req_valid, .tx_slot, .tx_remote, .tx_id, .tx_dlc, .tx_done,
    .tx_arb_lost, .tx_error, .bus_frame_end, .rx_done, .rx_remote, .rx_id, .rx_dlc, .rx_store,
    .rx_slot, .tx_int_req, .rx_int_req);
  cms_engine_model eng (.sys_clk, .rst, .tx_req_valid, .tx_slot, .tx_remote, .tx_id, .tx_dlc,
    .tx_done, .tx_arb_lost, .tx_error, .bus_frame_end, .rx_done, .rx_remote, .rx_id, .rx_dlc,
    .rx_store, .rx_slot);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (tx_int_req === 1'b1) n_txi++;
    if (rx_int_req === 1'b1) n_rxi++;
  end
  function automatic logic [7:0] ca(input int j);
    ca = CTRL_BASE + 8'(4 * j);
  endfunction : ca
  function automatic logic [31:0] ex(input logic [3:0] s, input logic r, input logic [3:0] d,
                                     input logic [10:0] i);
    ex = {12'h000, s, r, d, i};
  endfunction : ex
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // a gap cycle after each access keeps one assignment per signal and time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(reg_rdata, exp);
  endtask : rdc
  task automatic sl(input int j, input logic [7:0] c, input logic [10:0] id, input logic [3:0] d);
    wr(ID_BASE + 8'(4 * j), {12'h000, d, 5'h00, id});
    wr(ca(j), {24'h000000, c});
  endtask : sl
  task automatic wait_offers(input int n);
    for (int i = 0; i < 400 && eng.offers.size() < n; i++) @(posedge sys_clk);
  endtask : wait_offers
  task automatic wait_valid();
    for (int i = 0; i < 100 && tx_req_valid !== 1'b1; i++) @(posedge sys_clk);
  endtask : wait_valid
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #400000;
    n_errors++;
    wrap_up();
  end
  initial begin
    {rst, op_mode, dual_slot_mode, reg_wr, reg_rd} = 5'h10;
    reg_addr  = '0;
    reg_wdata = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    wr(INTEN_ADDR, 32'h0000FFFF);
    wr(ca(0), 32'h00000040);
    op_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdc(INTEN_ADDR, 32'h0);
    rdc(ca(0), 32'h0);
    rdc(8'hC0, 32'h0);
    wr(INTEN_ADDR, 32'h000001FF);
    rdc(INTEN_ADDR, 32'h000001FF);
    $display("test registers done");
    sl(9, 8'h80, 11'h109, 4'h3);
    sl(5, 8'h80, 11'h105, 4'h1);
    sl(2, 8'h80, 11'h102, 4'h2);
    wait_offers(3);
    chk(eng.offers[0], ex(4'h9, 1'b0, 4'h3, 11'h109));
    chk(eng.offers[1], ex(4'h2, 1'b0, 4'h2, 11'h102));
    chk(eng.offers[2], ex(4'h5, 1'b0, 4'h1, 11'h105));
    repeat (12) @(posedge sys_clk);
    rdc(ca(2), 32'h02);
    chk(n_txi, 2);
    $display("test transmit order done");
    eng.offers.delete();
    eng.n_lose = 1;
    sl(1, 8'h80, 11'h101, 4'h4);
    wait_offers(2);
    chk(eng.offers[1], ex(4'h1, 1'b0, 4'h4, 11'h101));
    repeat (12) @(posedge sys_clk);
    rdc(ca(1), 32'h02);
    for (int e = 0; e < 2; e++) begin
      eng.use_err = e[0];
      eng.n_lose  = 100;
      sl(3, 8'h80, 11'h103, 4'h1);
      wait_valid();
      wr(ca(3), 32'h0);
      repeat (20) @(posedge sys_clk);
      rdc(ca(3), 32'h0);
    end
    // response slot: clearing the receive request aborts; remote bit is kept while busy
    sl(12, 8'h60, 11'h10C, 4'h1);
    eng.rx_frame(1'b1, 11'h10C, 4'h2);
    wait_valid();
    wr(ca(12), 32'h0);
    repeat (20) @(posedge sys_clk);
    rdc(ca(12), 32'h20);
    eng.n_lose = 0;
    sl(4, 8'h80, 11'h104, 4'h1);
    wait_valid();
    wr(ca(4), 32'h0);
    repeat (20) @(posedge sys_clk);
    rdc(ca(4), 32'h02);
    $display("test retry and abort done");
    eng.offers.delete();
    sl(6, 8'h60, 11'h123, 4'h8);
    eng.rx_frame(1'b1, 11'h123, 4'h3);
    wait_offers(1);
    chk(eng.offers[0], ex(4'h6, 1'b0, 4'h3, 11'h123));
    repeat (12) @(posedge sys_clk);
    eng.offers.delete();
    sl(7, 8'h70, 11'h155, 4'h8);
    eng.rx_frame(1'b1, 11'h155, 4'h5);
    repeat (20) @(posedge sys_clk);
    chk(eng.offers.size(), 0);
    wr(ca(7), 32'h60);
    wait_offers(1);
    chk(eng.offers[0], ex(4'h7, 1'b0, 4'h5, 11'h155));
    repeat (12) @(posedge sys_clk);
    eng.offers.delete();
    dual_slot_mode <= 1'b1;
    sl(14, 8'h60, 11'h1AA, 4'h8);
    eng.rx_frame(1'b1, 11'h1AA, 4'h2);
    repeat (20) @(posedge sys_clk);
    chk(eng.offers.size(), 0);
    dual_slot_mode <= 1'b0;
    $display("test remote response done");
    sl(10, 8'h40, 11'h2F0, 4'h4);
    sl(8, 8'h40, 11'h2F0, 4'h4);
    eng.rx_frame(1'b0, 11'h2F0, 4'h4);
    eng.rx_frame(1'b1, 11'h2F0, 4'h4);
    eng.rx_frame(1'b0, 11'h2F0, 4'h4);
    repeat (2) @(posedge sys_clk);
    chk(eng.stores.size(), 2);
    chk(eng.stores[0], 8);
    chk(eng.stores[1], 8);
    rdc(ca(8), 32'h49);
    chk(n_rxi, 2);
    sl(11, 8'hA0, 11'h321, 4'h2);
    wait_offers(1);
    chk(eng.offers[0], ex(4'hB, 1'b1, 4'h2, 11'h321));
    repeat (12) @(posedge sys_clk);
    eng.rx_frame(1'b0, 11'h321, 4'h2);
    repeat (2) @(posedge sys_clk);
    chk(eng.stores[2], 11);
    $display("test receive done");
    op_mode <= 1'b0;
    repeat (2) @(posedge sys_clk);
    op_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdc(INTEN_ADDR, 32'h0);
    rdc(ca(8), 32'h0);
    rdc(ID_BASE + 8'h20, 32'h0);
    $display("test mode change done");
    wrap_up();
  end
endmodule : cms_slot_ctrl_tb
